/* logic/sram_defs.svh */
// constants of the serial register access map: selects, fields, resets, frame sizes
// assumes inclusion by the top module only; the register map package does not include it
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// ----------------------------------------------------------------
// register selects
// ----------------------------------------------------------------
`define SRAM_SEL_PRIMARY   3'h1
`define SRAM_SEL_IFACE     3'h2
`define SRAM_SEL_FLAGS     3'h3
`define SRAM_SEL_LOWER     3'h4
`define SRAM_SEL_UPPER     3'h5

// ----------------------------------------------------------------
// command word layout
// ----------------------------------------------------------------
`define SRAM_CMD_DIR_BIT   15
`define SRAM_CMD_SEL_HI    14
`define SRAM_CMD_SEL_LO    12
`define SRAM_CMD_DATA_HI   11

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRAM_P_PAIR        11
`define SRAM_P_SEQ         10
`define SRAM_P_STYLE       9
`define SRAM_P_RATIO_HI    8
`define SRAM_P_RATIO_LO    6
`define SRAM_P_WCHK        5
`define SRAM_P_RCHK        4
`define SRAM_P_FLAGEN      3
`define SRAM_P_PREC        2
`define SRAM_P_REF         1
`define SRAM_P_PWR         0
`define SRAM_I_LANES       8
`define SRAM_F_WFAIL       9
`define SRAM_F_SETUP       8
`define SRAM_F_B_OVER      5
`define SRAM_F_B_UNDER     4
`define SRAM_F_A_OVER      1
`define SRAM_F_A_UNDER     0

// ----------------------------------------------------------------
// reset values, frame sizes and checksum polynomial
// ----------------------------------------------------------------
`define SRAM_RST_PRIMARY   12'h000
`define SRAM_RST_IFACE     12'h000
`define SRAM_RST_FLAGS     12'h000
`define SRAM_RST_LOWER     12'h000
`define SRAM_RST_UPPER     12'hFFF
`define SRAM_FRAME_SHORT   5'h10
`define SRAM_FRAME_LONG    5'h18
`define SRAM_CRC_POLY      8'h07

`endif

/* logic/sram_pkg.sv */
// types of the serial register access map
// assumes sram_defs.svh sits beside it
package sram_pkg;

    typedef enum logic [1:0] {
        SRAM_ST_IDLE   = 2'b00,
        SRAM_ST_SHIFT  = 2'b01,
        SRAM_ST_COMMIT = 2'b11
    } sram_state_t;

    // decoded primary configuration fields
    typedef struct packed {
        logic       input_pair_select;
        logic       pair_sequencer_enable;
        logic       averaging_style;
        logic [2:0] averaging_ratio;
        logic       write_check_en;
        logic       read_check_en;
        logic       flag_pin_en;
        logic       extra_precision;
        logic       reference_choice;
        logic       power_choice;
    } sram_cfg_t;

    // limit and setup events from the compare logic outside
    typedef struct packed {
        logic conv_a_over_flag;
        logic conv_a_under_flag;
        logic conv_b_over_flag;
        logic conv_b_under_flag;
        logic setup_flag;
    } sram_evt_t;

endpackage

/* logic/sram_top.sv */
// serial register access map: command decoder and register bank
// assumes a serial host drives sclk/cs_n/sdi; those three pins are asynchronous to clk_i
//
// Functional notes
// [R1] sixteen clock frame, command MSB first
// [R2] bit 15 direction, bits 14:12 select
// [R3] write loads twelve payload bits to register
// [R4] valid read shifts register out next frame
// [R5] selects 0, 6, 7 read give conversion data
// [R6] writes to unlisted selects change nothing
// [R7] writes to read-only flags are discarded
// [R8] reads to write-only registers are discarded
// [R9] primary config at 1, zero reset, echo
// [R10] primary config upper field placement
// [R11] primary config low byte field placement
// [R12] pair select picks channel pair 0/1
// [R13] sequencer alternates pairs, else selected pair
// [R14] interface config at 2: lanes, reset field
// [R15] read-only event flags at 3, zero reset
// [R16] lower limit at 4, resets zero
// [R17] upper limit at 5, resets all ones
// [R18] host follows read with another frame
// [R19] write checking extends frame to 24 bits
// [R20] check bit change, checked writes need CRC
// [R21] checksum polynomial x^8+x^2+x+1
// [R22] commit only on complete frame at deselect
`timescale 1ns/1ps

`include "sram_defs.svh"

module sram_top
    import sram_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // serial pins
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        sdi_i,
    output logic             primary_out_pin_o,
    output logic             primary_out_en_o,
    // converter side
    input  wire logic [15:0] conv_data_i,
    input  wire logic        conv_done_i,
    input  wire sram_evt_t   evt_i,
    output sram_cfg_t        cfg_o,
    output logic             active_pair_o,
    output logic             output_lane_count_o,
    output logic [7:0]       soft_reset_field_o,
    output logic [11:0]      lower_limit_o,
    output logic [11:0]      upper_limit_o
);

    // ----------------------------------------------------------------
    // checksum
    // ----------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [15:0] data);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ data[i]) begin
                c = {c[6:0], 1'b0} ^ `SRAM_CRC_POLY; // R21
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and edges
    // ----------------------------------------------------------------
    logic [2:0]  sclk_sync;
    logic [2:0]  cs_sync;
    logic [1:0]  sdi_sync;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        cs_low;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_sync <= 3'h0;
            cs_sync   <= 3'h7;
            sdi_sync  <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk_i};
            cs_sync   <= {cs_sync[1:0], cs_n_i};
            sdi_sync  <= {sdi_sync[0], sdi_i};
        end
    end

    // only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    assign cs_fall   = ~cs_sync[1] & cs_sync[2];
    assign cs_rise   = cs_sync[1] & ~cs_sync[2];
    assign cs_low    = ~cs_sync[2];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [11:0] primary_config;
    logic [11:0] interface_config;
    logic [11:0] event_flags;
    logic [11:0] lower_limit_reg;
    logic [11:0] upper_limit_reg;

    // ----------------------------------------------------------------
    // frame receive
    // ----------------------------------------------------------------
    sram_state_t state;
    logic [23:0] rx_sr;
    logic [4:0]  bit_cnt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= SRAM_ST_IDLE;
        end else begin
            unique case (state)
                SRAM_ST_IDLE: begin
                    if (cs_fall) begin
                        state <= SRAM_ST_SHIFT;
                    end
                end
                SRAM_ST_SHIFT: begin
                    if (cs_rise) begin
                        state <= SRAM_ST_COMMIT; // R22
                    end
                end
                SRAM_ST_COMMIT: begin
                    state <= SRAM_ST_IDLE;
                end
                default: begin
                    state <= SRAM_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_sr   <= 24'h000000;
            bit_cnt <= 5'h00;
        end else if (cs_fall) begin
            rx_sr   <= 24'h000000;
            bit_cnt <= 5'h00;
        end else if (state == SRAM_ST_SHIFT && cs_low && sclk_rise) begin
            rx_sr <= {rx_sr[22:0], sdi_sync[1]}; // R1
            if (bit_cnt != 5'h1F) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic        long_frame;
    logic        short_frame;
    logic [15:0] cmd;
    logic        cmd_write;
    logic [2:0]  cmd_sel;
    logic [11:0] cmd_data;
    logic        crc_ok;
    logic        sel_valid;
    logic        write_ok;
    logic        commit;

    assign long_frame  = (bit_cnt == `SRAM_FRAME_LONG);
    assign short_frame = (bit_cnt == `SRAM_FRAME_SHORT);
    // in a long frame the checksum trails the command word
    assign cmd         = long_frame ? rx_sr[23:8] : rx_sr[15:0]; // R19
    assign cmd_write   = cmd[`SRAM_CMD_DIR_BIT]; // R2
    assign cmd_sel     = cmd[`SRAM_CMD_SEL_HI:`SRAM_CMD_SEL_LO]; // R2
    assign cmd_data    = cmd[`SRAM_CMD_DATA_HI:0];
    assign crc_ok      = long_frame && (crc8(cmd) == rx_sr[7:0]); // R21
    assign sel_valid   = (cmd_sel >= `SRAM_SEL_PRIMARY) && (cmd_sel <= `SRAM_SEL_UPPER); // R5
    assign commit      = (state == SRAM_ST_COMMIT) && (short_frame || long_frame); // R22

    always_comb begin
        if (primary_config[`SRAM_P_WCHK]) begin
            write_ok = crc_ok; // R20
        end else if (cmd_sel == `SRAM_SEL_PRIMARY && cmd_data[`SRAM_P_WCHK]) begin
            write_ok = crc_ok; // R20
        end else begin
            write_ok = short_frame; // R1
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    logic do_write;
    assign do_write = commit && cmd_write && write_ok;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            primary_config   <= `SRAM_RST_PRIMARY; // R9
            interface_config <= `SRAM_RST_IFACE; // R14
            lower_limit_reg  <= `SRAM_RST_LOWER; // R16
            upper_limit_reg  <= `SRAM_RST_UPPER; // R17
        end else if (do_write) begin
            unique case (cmd_sel)
                `SRAM_SEL_PRIMARY: primary_config   <= cmd_data; // R3
                `SRAM_SEL_IFACE:   interface_config <= cmd_data; // R3
                `SRAM_SEL_LOWER:   lower_limit_reg  <= cmd_data; // R3
                `SRAM_SEL_UPPER:   upper_limit_reg  <= cmd_data; // R3
                // flags are read-only; other selects are no-ops
                default: ; // R6 R7
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pending read
    // ----------------------------------------------------------------
    logic       pend_valid;
    logic [2:0] pend_sel;
    logic       load_tx;

    assign load_tx = cs_fall;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_valid <= 1'b0;
            pend_sel   <= 3'h0;
        end else if (commit && !cmd_write) begin
            // every register is readable, so no read is dropped as write-only
            pend_valid <= sel_valid; // R4 R5 R8
            pend_sel   <= cmd_sel;
        end else if (load_tx) begin
            pend_valid <= 1'b0; // R18
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    logic flags_read;
    logic wfail_evt;
    logic [11:0] flag_set;

    assign flags_read = load_tx && pend_valid && pend_sel == `SRAM_SEL_FLAGS;
    assign wfail_evt  = commit && cmd_write && primary_config[`SRAM_P_WCHK] && !crc_ok;

    always_comb begin
        flag_set = 12'h000;
        flag_set[`SRAM_F_WFAIL]   = wfail_evt;
        flag_set[`SRAM_F_SETUP]   = evt_i.setup_flag;
        flag_set[`SRAM_F_B_OVER]  = evt_i.conv_b_over_flag;
        flag_set[`SRAM_F_B_UNDER] = evt_i.conv_b_under_flag;
        flag_set[`SRAM_F_A_OVER]  = evt_i.conv_a_over_flag;
        flag_set[`SRAM_F_A_UNDER] = evt_i.conv_a_under_flag;
    end

    // clear on readout; a set in the same cycle survives
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_flags <= `SRAM_RST_FLAGS; // R15
        end else if (flags_read) begin
            event_flags <= flag_set; // R15
        end else begin
            event_flags <= event_flags | flag_set; // R15
        end
    end

    // ----------------------------------------------------------------
    // transmit
    // ----------------------------------------------------------------
    logic [11:0] rd_data;
    logic [15:0] tx_word;
    logic [23:0] tx_sr;

    always_comb begin
        unique case (pend_sel)
            `SRAM_SEL_PRIMARY: rd_data = primary_config;
            `SRAM_SEL_IFACE:   rd_data = interface_config;
            `SRAM_SEL_FLAGS:   rd_data = event_flags;
            `SRAM_SEL_LOWER:   rd_data = lower_limit_reg;
            `SRAM_SEL_UPPER:   rd_data = upper_limit_reg;
            default:           rd_data = 12'h000;
        endcase
    end

    // register readback carries its own select as address echo
    assign tx_word = pend_valid ? {1'b0, pend_sel, rd_data} : conv_data_i; // R4 R5 R9

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_sr <= 24'h000000;
        end else if (load_tx) begin
            if (primary_config[`SRAM_P_RCHK]) begin
                tx_sr <= {tx_word, crc8(tx_word)};
            end else begin
                tx_sr <= {tx_word, 8'h00};
            end
        end else if (cs_low && sclk_fall) begin
            tx_sr <= {tx_sr[22:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            primary_out_en_o <= 1'b0;
        end else begin
            primary_out_en_o <= cs_low;
        end
    end

    assign primary_out_pin_o = tx_sr[23];

    // ----------------------------------------------------------------
    // configuration outputs
    // ----------------------------------------------------------------
    logic pair_toggle;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pair_toggle <= 1'b0;
        end else if (!primary_config[`SRAM_P_SEQ]) begin
            pair_toggle <= 1'b0;
        end else if (conv_done_i) begin
            pair_toggle <= ~pair_toggle; // R13
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_pair_o <= 1'b0;
        end else if (primary_config[`SRAM_P_SEQ]) begin
            active_pair_o <= pair_toggle; // R13
        end else begin
            active_pair_o <= primary_config[`SRAM_P_PAIR]; // R12
        end
    end

    always_comb begin
        cfg_o.input_pair_select     = primary_config[`SRAM_P_PAIR]; // R10
        cfg_o.pair_sequencer_enable = primary_config[`SRAM_P_SEQ]; // R10
        cfg_o.averaging_style       = primary_config[`SRAM_P_STYLE]; // R10
        cfg_o.averaging_ratio       = primary_config[`SRAM_P_RATIO_HI:`SRAM_P_RATIO_LO]; // R10
        cfg_o.write_check_en        = primary_config[`SRAM_P_WCHK]; // R11
        cfg_o.read_check_en         = primary_config[`SRAM_P_RCHK]; // R11
        cfg_o.flag_pin_en           = primary_config[`SRAM_P_FLAGEN]; // R11
        cfg_o.extra_precision       = primary_config[`SRAM_P_PREC]; // R11
        cfg_o.reference_choice      = primary_config[`SRAM_P_REF]; // R11
        cfg_o.power_choice          = primary_config[`SRAM_P_PWR]; // R11
    end

    assign output_lane_count_o = interface_config[`SRAM_I_LANES]; // R14
    assign soft_reset_field_o  = interface_config[7:0]; // R14
    assign lower_limit_o       = lower_limit_reg;
    assign upper_limit_o       = upper_limit_reg;

endmodule // sram_top

/* tb/sram_top_checker.sv */
// pin-level assertions for the serial register map: framing, output enable, commit timing, pair choice
// assumes it is bound into sram_top and sees only that module's ports
`timescale 1ns/1ps

module sram_top_checker
    import sram_pkg::*;
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // serial side
    input wire logic        cs_n_i,
    input wire logic        primary_out_pin_o,
    input wire logic        primary_out_en_o,
    // converter side
    input wire logic        conv_done_i,
    input wire sram_cfg_t   cfg_o,
    input wire logic        active_pair_o,
    input wire logic        output_lane_count_o,
    input wire logic [7:0]  soft_reset_field_o,
    input wire logic [11:0] lower_limit_o,
    input wire logic [11:0] upper_limit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // frame phases, long enough to cover the pin synchronisers
    // ----------------------------------------------------------------
    sequence s_selected;
        !cs_n_i [*5];
    endsequence
    sequence s_idle;
        cs_n_i [*6];
    endsequence

    a_en_frame: assert property (s_selected |-> primary_out_en_o)
        else $error("output enable low inside a frame");
    a_en_idle: assert property (s_idle |-> !primary_out_en_o)
        else $error("output enable high between frames");
    a_out_hold: assert property (s_idle |-> $stable(primary_out_pin_o))
        else $error("serial output moved between frames");
    a_no_midframe: assert property (s_selected |-> $stable(cfg_o) && $stable(lower_limit_o)
        && $stable(upper_limit_o))
        else $error("register output changed inside a frame");
    a_commit_late: assert property (!$stable({cfg_o, output_lane_count_o, soft_reset_field_o, lower_limit_o,
        upper_limit_o}) |-> $past(cs_n_i) && $past(cs_n_i, 2))
        else $error("register output changed before frame end");
    a_pair_follow: assert property (!cfg_o.pair_sequencer_enable && $stable(cfg_o)
        |-> active_pair_o == cfg_o.input_pair_select)
        else $error("active pair differs from selected pair");
    // the pair output trails the internal toggle by one register stage
    a_seq_toggle: assert property (cfg_o.pair_sequencer_enable && $stable(cfg_o) && conv_done_i
        |-> ##2 active_pair_o != $past(active_pair_o, 2))
        else $error("sequencer did not alternate pair");
    a_seq_hold: assert property (cfg_o.pair_sequencer_enable && $stable(cfg_o) && !conv_done_i
        && !$past(conv_done_i) |=> $stable(active_pair_o))
        else $error("pair changed without a conversion");
    a_reset_vals: assert property ($rose(rst_n_i) |-> upper_limit_o == 12'hFFF && lower_limit_o == 12'h000
        && cfg_o == '0 && !primary_out_en_o)
        else $error("wrong value after reset");
endmodule // sram_top_checker

bind sram_top sram_top_checker sram_top_checker_i (.clk_i, .rst_n_i, .cs_n_i, .primary_out_pin_o,
    .primary_out_en_o, .conv_done_i, .cfg_o, .active_pair_o, .output_lane_count_o, .soft_reset_field_o,
    .lower_limit_o, .upper_limit_o);

/* tb/sram_host_model.sv */
// host serial controller: shifts command frames in, gathers the readback
// assumes an 800 ns serial clock that stands low outside frames
`timescale 1ns/1ps

module sram_host_model (
    // serial pins
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // n bits sent from bit 23 down; odd offset keeps the link unrelated to clk
    task automatic frame(input int n, input logic [23:0] w, output logic [23:0] rx);
        rx = '0;
        #37;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi_o = w[23-i];
            #400;
            sclk_o = 1'b1;
            #400;
            // sampled late: the output moves a few clocks after each fall
            rx[23-i] = sdo_i;
            sclk_o = 1'b0;
        end
        #400;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #800;
    endtask
endmodule // sram_host_model

/* tb/sram_top_tb.sv */
// self-checking bench for the serial register map, with a register model and random traffic
// assumes sram_host_model drives the serial pins
`timescale 1ns/1ps

module sram_top_tb;
    import sram_pkg::*;
    logic        clk_i, rst_n_i, sclk_i, cs_n_i, sdi_i, primary_out_pin_o, primary_out_en_o;
    logic [15:0] conv_data_i;
    logic        conv_done_i, active_pair_o, output_lane_count_o, pv, p;
    sram_evt_t   evt_i;
    sram_cfg_t   cfg_o;
    logic [7:0]  soft_reset_field_o;
    logic [11:0] lower_limit_o, upper_limit_o, flags;
    logic [11:0] m [8];
    logic [2:0]  pend;
    logic [15:0] lf;
    logic [23:0] rx;
    int          err_count, n_tests;

    sram_top sram_top_i (.clk_i, .rst_n_i, .sclk_i, .cs_n_i, .sdi_i, .primary_out_pin_o, .primary_out_en_o,
        .conv_data_i, .conv_done_i, .evt_i, .cfg_o, .active_pair_o, .output_lane_count_o,
        .soft_reset_field_o, .lower_limit_o, .upper_limit_o);
    sram_host_model sram_host_model_i (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i),
        .sdo_i(primary_out_pin_o));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] crc8(logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    function automatic logic [15:0] lfsr_next(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [23:0] cw(logic [15:0] c);
        return {c, crc8(c)};
    endfunction
    function automatic logic [15:0] rb(logic [2:0] s);
        if (s == 3'h0 || s > 3'h5) return conv_data_i;
        return {1'b0, s, (s == 3'h3) ? flags : m[s]};
    endfunction

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    task automatic finish_test();
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic pulse(input sram_evt_t e);
        @(posedge clk_i) evt_i <= e;
        @(posedge clk_i) evt_i <= '0;
        flags |= {3'h0, e.setup_flag, 2'h0, e.conv_b_over_flag, e.conv_b_under_flag, 2'h0,
            e.conv_a_over_flag, e.conv_a_under_flag};
    endtask

    // one frame, then readback and register outputs against the model
    task automatic xfer(input int n, input logic [23:0] w);
        logic [15:0] c;
        logic [15:0] e;
        logic        wen;
        c = w[23:8];
        @(posedge clk_i) conv_data_i <= lf;
        lf = lfsr_next(lf);
        sram_host_model_i.frame(n, w, rx);
        e = rb(pend);
        if (pv) chk("readback", {8'h00, e}, {8'h00, rx[23:8]});
        if (pv && n == 24 && m[1][4] && pend inside {[3'h1:3'h5]}) chk("rdcrc", 24'(crc8(e)), 24'(rx[7:0]));
        if (pv && pend == 3'h3) flags = '0;
        pv = (n == 16 || n == 24);
        wen = pv && c[15];
        if (wen && (m[1][5] || (c[14:12] == 3'h1 && c[5])) && !(n == 24 && w[7:0] == crc8(c))) begin
            flags[9] = flags[9] | m[1][5];
            wen = 1'b0;
        end
        // unchecked writes only count in a plain sixteen bit frame
        if (!(m[1][5] || (c[14:12] == 3'h1 && c[5])) && n != 16) wen = 1'b0;
        if (wen && c[14:12] inside {3'h1, 3'h2, 3'h4, 3'h5}) m[c[14:12]] = c[11:0];
        pend = c[15] ? 3'h0 : c[14:12];
        chk("cfg", 24'(m[1]), 24'(cfg_o));
        chk("iface", 24'(m[2][8:0]), 24'({output_lane_count_o, soft_reset_field_o}));
        chk("limits", {m[4], m[5]}, {lower_limit_o, upper_limit_o});
    endtask

    initial begin
        #5000000;
        err_count++;
        finish_test();
    end

    initial begin
        rst_n_i = 1'b0;
        conv_data_i = 16'h0000;
        conv_done_i = 1'b0;
        evt_i = '0;
        err_count = 0;
        n_tests = 0;
        lf = 16'h59EE;
        m = '{default: 12'h000};
        m[5] = 12'hFFF;
        flags = 12'h000;
        pend = 3'h0;
        pv = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int s = 0; s < 9; s++) xfer(16, {1'b0, 3'(s), 20'h0});
        for (int k = 0; k < 40; k++) begin
            if (k % 8 == 0) pulse(sram_evt_t'(lf[4:0]));
            xfer(16, {lf[15:6], 1'b0, lf[4:0], 8'h00});
        end
        pulse(sram_evt_t'(5'h1F));
        xfer(16, {16'h3000, 8'h00});
        xfer(16, {16'hBFFF, 8'h00});
        xfer(16, {16'h3000, 8'h00});
        xfer(12, {16'hCABC, 8'h00});
        xfer(16, {16'h9020, 8'h00});
        xfer(24, cw(16'h9020));
        xfer(16, {16'hC123, 8'h00});
        xfer(24, {16'hC123, ~crc8(16'hC123)});
        xfer(24, cw(16'hC456));
        xfer(24, cw(16'h9030));
        xfer(24, {16'h3000, 8'h00});
        xfer(24, {16'h5000, 8'h00});
        xfer(24, cw(16'h9000));
        xfer(24, cw(16'hC777));
        xfer(16, {16'h9800, 8'h00});
        chk("pair", 24'h1, 24'(active_pair_o));
        xfer(16, {16'h9C00, 8'h00});
        for (int k = 0; k < 4; k++) begin
            p = active_pair_o;
            @(posedge clk_i) conv_done_i <= 1'b1;
            @(posedge clk_i) conv_done_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk("pair", {23'h0, ~p}, 24'(active_pair_o));
        end
        xfer(16, {16'h9000, 8'h00});
        chk("pair", 24'h0, 24'(active_pair_o));
        xfer(16, 24'h000000);
        finish_test();
    end
endmodule // sram_top_tb
